// ===== pkg/rmadc_regs.svh
`ifndef RMADC_REGS_SVH
`define RMADC_REGS_SVH
// register indices; byte address is four times the index
`define RMADC_IDX_RX_MODE      6'h13
`define RMADC_IDX_DRV_CTRL     6'h14
`define RMADC_IDX_DRV_AUTO     6'h15
`define RMADC_IDX_SRC_SEL      6'h16
`define RMADC_RST_RX_MODE      8'h00
`define RMADC_RST_DRV_CTRL     8'h80
`define RMADC_RST_DRV_AUTO     8'h00
`define RMADC_RST_SRC_SEL      8'h10
// receive mode fields
`define RMADC_BIT_CRC_EN       7
`define RMADC_BIT_NO_ERR       3
`define RMADC_RATE_HI          6
`define RMADC_RATE_LO          4
`define RMADC_FRM_HI           1
`define RMADC_FRM_LO           0
`define RMADC_RATE_106         3'h0
`define RMADC_RATE_424         3'h2
`define RMADC_FRM_ISO          2'h0
`define RMADC_FRM_ALT          2'h2
// driver fields
`define RMADC_BIT_INV_TWO      5
`define RMADC_BIT_INV_ONE      4
`define RMADC_BIT_WAKE_EN      5
`define RMADC_DRV_HI           5
`define RMADC_DRV_LO           4
`define RMADC_SIG_HI           3
`define RMADC_SIG_LO           0
// write masks: reserved bits read back as zero
`define RMADC_MASK_DRV_AUTO    8'hEF
`define RMADC_MASK_SRC_SEL     8'h3F
`define RMADC_MIN_FRAME_BITS   4'h4
`define RMADC_CRC_POLY         16'h1021
`define RMADC_CRC_PRESET_ISO   16'h6363
`define RMADC_CRC_PRESET_ALT   16'h0000
`endif

// ===== pkg/rmadc_pkg.sv
package rmadc_pkg;
  typedef logic [2:0] rmadc_rate_t;
  typedef logic [1:0] rmadc_frame_t;
  typedef logic [1:0] rmadc_drv_src_t;
  typedef logic [3:0] rmadc_sig_src_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  rx_mode;
    logic [7:0]  drv_ctrl;
    logic [7:0]  drv_auto;
    logic [7:0]  src_sel;
    logic        external_signal_input_s1;
    logic        external_signal_input_s2;
    logic        field_s1;
    logic        field_s2;
    logic        field_prev;
    logic        pd_prev;
    logic        wake;
    logic [15:0] crc;
    logic [3:0]  bit_cnt;
    logic        rx_active;
    logic        frame_ok;
    logic        crc_err;
    logic        short_ign;
    logic        short_err;
    logic        drv1;
    logic        drv1_oe;
    logic        drv2;
    logic        drv2_oe;
    logic        external_signal_output;
    logic        external_signal_output_oe;
  } rmadc_state_s;
endpackage : rmadc_pkg

// ===== verilog/rmadc_config_regs.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
`include "rmadc_regs.svh"
// Functional notes
// - checksum enable set: received frames are checked with a CRC
// - receive bit rate codes 000, 001, 010 give 106, 212, 424 kbit
// - ignore_short_frames: under 4 bits dropped, receiver stays active
// - frame format 00 is 14443A at 106, 10 the alternate framing
// - receive mode at 13h, reset 00h, rate and format set by hardware
// - driver control bit 5 inverts antenna driver two
// - driver control bit 4 inverts antenna driver one
// - driver control register at 14h, reset 80h
// - field_wake_enable set: field detection ends soft power-down
// - driver auto register at 15h, reset 00h, bit 4 reserved
// - source select: driver source 5:4, signal output 3:0, reset 10h
// - driver source: float, coder envelope, external input, high
// - in soft power-down drivers float only when source is tristate
// - signal output: float, low, high, coder, transmit, receive stream
module rmadc_config_regs (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   mode_update_i,
  input  wire rmadc_pkg::rmadc_rate_t mode_update_rate_i,
  input  wire rmadc_pkg::rmadc_frame_t mode_update_format_i,
  input  wire logic                   rx_start_i,
  input  wire logic                   rx_bit_valid_i,
  input  wire logic                   rx_bit_i,
  input  wire logic                   rx_frame_end_i,
  output logic                        rx_active_o,
  output logic                        rx_frame_ok_o,
  output logic                        rx_crc_error_o,
  output logic                        rx_short_ignored_o,
  output logic                        rx_short_error_o,
  output rmadc_pkg::rmadc_rate_t      receive_bit_rate_o,
  output rmadc_pkg::rmadc_frame_t     receive_frame_format_o,
  output logic                        receive_checksum_enable_o,
  input  wire logic                   soft_power_down_i,
  input  wire logic                   rf_field_detect_i,
  output logic                        field_wake_o,
  input  wire logic                   coder_envelope_i,
  input  wire logic                   tx_serial_i,
  input  wire logic                   rx_serial_i,
  input  wire logic                   external_signal_input_i,
  output logic                        antenna_driver_pin_one_o,
  output logic                        antenna_driver_pin_one_oe_o,
  output logic                        antenna_driver_pin_two_o,
  output logic                        antenna_driver_pin_two_oe_o,
  output logic                        external_signal_output_o,
  output logic                        external_signal_output_oe_o
);
  import rmadc_pkg::*;

  rmadc_state_s q;
  rmadc_state_s d;

  logic           req;
  logic           wr;
  logic [5:0]     idx;
  rmadc_rate_t    rate_raw;
  rmadc_frame_t   frm_raw;
  rmadc_drv_src_t drv_src;
  rmadc_sig_src_t sig_src;
  logic           drv_val;
  logic           crc_fb;
  logic           short_frame;
  logic           crc_bad;

  assign req     = wb_cyc_i && wb_stb_i && !q.ack;
  // write lands on the edge at which the master samples ack
  assign wr      = wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0];
  assign idx     = wb_adr_i[7:2];
  assign rate_raw = q.rx_mode[`RMADC_RATE_HI:`RMADC_RATE_LO];
  assign frm_raw  = q.rx_mode[`RMADC_FRM_HI:`RMADC_FRM_LO];
  assign drv_src  = q.src_sel[`RMADC_DRV_HI:`RMADC_DRV_LO];
  assign sig_src  = q.src_sel[`RMADC_SIG_HI:`RMADC_SIG_LO];
  assign short_frame = q.bit_cnt < `RMADC_MIN_FRAME_BITS;
  assign crc_bad = q.rx_mode[`RMADC_BIT_CRC_EN] && (q.crc != 16'h0000);
  assign crc_fb  = q.crc[15] ^ rx_bit_i;

  // unsupported codes fall back to the base setting
  always_comb begin
    if (rate_raw > `RMADC_RATE_424) begin
      receive_bit_rate_o = `RMADC_RATE_106;
    end else begin
      receive_bit_rate_o = rate_raw;
    end
    if (frm_raw == `RMADC_FRM_ALT) begin
      receive_frame_format_o = `RMADC_FRM_ALT;
    end else begin
      receive_frame_format_o = `RMADC_FRM_ISO;
    end
  end

  always_comb begin
    case (drv_src)
      2'h1:    drv_val = coder_envelope_i;
      2'h2:    drv_val = q.external_signal_input_s2;
      2'h3:    drv_val = 1'b1;
      default: drv_val = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.ack = req;
    // bus side
    if (req) begin
      case (idx)
        `RMADC_IDX_RX_MODE:  d.rdata = q.rx_mode;
        `RMADC_IDX_DRV_CTRL: d.rdata = q.drv_ctrl;
        `RMADC_IDX_DRV_AUTO: d.rdata = q.drv_auto;
        `RMADC_IDX_SRC_SEL:  d.rdata = q.src_sel;
        default:             d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      case (idx)
        `RMADC_IDX_RX_MODE:  d.rx_mode = wb_dat_i[7:0];
        `RMADC_IDX_DRV_CTRL: d.drv_ctrl = wb_dat_i[7:0];
        `RMADC_IDX_DRV_AUTO:
          d.drv_auto = wb_dat_i[7:0] & `RMADC_MASK_DRV_AUTO;
        `RMADC_IDX_SRC_SEL:
          d.src_sel = wb_dat_i[7:0] & `RMADC_MASK_SRC_SEL;
        default: d.rx_mode = q.rx_mode;
      endcase
    end
    // hardware update of rate and format wins over a same-cycle write
    if (mode_update_i) begin
      d.rx_mode[`RMADC_RATE_HI:`RMADC_RATE_LO] = mode_update_rate_i;
      d.rx_mode[`RMADC_FRM_HI:`RMADC_FRM_LO] = mode_update_format_i;
    end

    // pin synchronisers
    d.external_signal_input_s1 = external_signal_input_i;
    d.external_signal_input_s2 = q.external_signal_input_s1;
    d.field_s1 = rf_field_detect_i;
    d.field_s2 = q.field_s1;
    d.field_prev = q.field_s2;
    d.pd_prev = soft_power_down_i;

    // wake on a new field, or a field already present at power-down entry
    d.wake = q.drv_auto[`RMADC_BIT_WAKE_EN] && soft_power_down_i
             && q.field_s2 && (!q.field_prev || !q.pd_prev)
             && !q.wake;

    // receive checking
    d.frame_ok = 1'b0;
    d.crc_err = 1'b0;
    d.short_ign = 1'b0;
    d.short_err = 1'b0;
    if (rx_bit_valid_i) begin
      d.crc = {q.crc[14:0], 1'b0} ^ (crc_fb ? `RMADC_CRC_POLY : 16'h0000);
      if (q.bit_cnt != 4'hF) begin
        d.bit_cnt = q.bit_cnt + 4'h1;
      end
    end
    if (rx_frame_end_i && q.rx_active) begin
      if (short_frame) begin
        if (q.rx_mode[`RMADC_BIT_NO_ERR]) begin
          d.short_ign = 1'b1;
        end else begin
          d.short_err = 1'b1;
          d.rx_active = 1'b0;
        end
      end else begin
        d.crc_err = crc_bad;
        d.frame_ok = !crc_bad;
        d.rx_active = 1'b0;
      end
    end
    // every frame boundary restarts count and checksum
    if (rx_frame_end_i || rx_start_i) begin
      d.bit_cnt = 4'h0;
      d.crc = (receive_frame_format_o == `RMADC_FRM_ALT) ?
              `RMADC_CRC_PRESET_ALT : `RMADC_CRC_PRESET_ISO;
    end
    if (rx_start_i) begin
      d.rx_active = 1'b1;
    end

    // drivers follow the source even in power-down unless set to float
    d.drv1_oe = drv_src != 2'h0;
    d.drv2_oe = drv_src != 2'h0;
    d.drv1 = drv_val ^ q.drv_ctrl[`RMADC_BIT_INV_ONE];
    d.drv2 = drv_val ^ q.drv_ctrl[`RMADC_BIT_INV_TWO];

    // codes not listed float the pin
    d.external_signal_output_oe = 1'b1;
    case (sig_src)
      4'h1:    d.external_signal_output = 1'b0;
      4'h2:    d.external_signal_output = 1'b1;
      4'h4:    d.external_signal_output = coder_envelope_i;
      4'h5:    d.external_signal_output = tx_serial_i;
      4'h7:    d.external_signal_output = rx_serial_i;
      default: begin
        d.external_signal_output = 1'b0;
        d.external_signal_output_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.rx_mode <= `RMADC_RST_RX_MODE;
      q.drv_ctrl <= `RMADC_RST_DRV_CTRL;
      q.drv_auto <= `RMADC_RST_DRV_AUTO;
      q.src_sel <= `RMADC_RST_SRC_SEL;
      q.crc <= `RMADC_CRC_PRESET_ISO;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.rdata};
  assign rx_active_o = q.rx_active;
  assign rx_frame_ok_o = q.frame_ok;
  assign rx_crc_error_o = q.crc_err;
  assign rx_short_ignored_o = q.short_ign;
  assign rx_short_error_o = q.short_err;
  assign receive_checksum_enable_o = q.rx_mode[`RMADC_BIT_CRC_EN];
  assign field_wake_o = q.wake;
  assign antenna_driver_pin_one_o = q.drv1;
  assign antenna_driver_pin_one_oe_o = q.drv1_oe;
  assign antenna_driver_pin_two_o = q.drv2;
  assign antenna_driver_pin_two_oe_o = q.drv2_oe;
  assign external_signal_output_o = q.external_signal_output;
  assign external_signal_output_oe_o = q.external_signal_output_oe;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  reset_values_a: assert property (
    $past(rst_i) |-> (q.rx_mode == `RMADC_RST_RX_MODE)
      && (q.drv_ctrl == `RMADC_RST_DRV_CTRL)
      && (q.drv_auto == `RMADC_RST_DRV_AUTO)
      && (q.src_sel == `RMADC_RST_SRC_SEL))
    else $error("register reset value wrong");

  wr_rx_mode_a: assert property (
    (wr && idx == `RMADC_IDX_RX_MODE && !mode_update_i)
      |=> q.rx_mode == $past(wb_dat_i[7:0]))
    else $error("receive mode write lost");

  crc_check_a: assert property (
    (rx_frame_end_i && q.rx_active && !short_frame
      && q.rx_mode[`RMADC_BIT_CRC_EN] && q.crc != 16'h0000)
      |=> rx_crc_error_o && !rx_frame_ok_o && !rx_active_o)
    else $error("bad checksum not flagged");

  crc_off_a: assert property (
    (rx_frame_end_i && q.rx_active && !short_frame
      && !q.rx_mode[`RMADC_BIT_CRC_EN]) |=> rx_frame_ok_o)
    else $error("frame rejected with checksum off");

  short_ignore_a: assert property (
    (rx_frame_end_i && q.rx_active && short_frame && !rx_start_i
      && q.rx_mode[`RMADC_BIT_NO_ERR])
      |=> rx_short_ignored_o && rx_active_o && !rx_frame_ok_o)
    else $error("short frame not silently dropped");

  short_error_a: assert property (
    (rx_frame_end_i && q.rx_active && short_frame && !rx_start_i
      && !q.rx_mode[`RMADC_BIT_NO_ERR])
      |=> rx_short_error_o && !rx_active_o)
    else $error("short frame not reported");

  rate_fallback_a: assert property (
    (rate_raw > `RMADC_RATE_424) |-> receive_bit_rate_o == `RMADC_RATE_106)
    else $error("unsupported rate not mapped to base rate");

  drv_float_a: assert property (
    (drv_src == 2'h0) |=> !antenna_driver_pin_one_oe_o
      && !antenna_driver_pin_two_oe_o)
    else $error("drivers not floating in tristate source");

  drv_inv_a: assert property (
    (drv_src == 2'h3) |=> antenna_driver_pin_one_oe_o
      && antenna_driver_pin_one_o == !$past(q.drv_ctrl[4])
      && antenna_driver_pin_two_o == !$past(q.drv_ctrl[5]))
    else $error("driver inversion wrong");

  wake_cause_a: assert property (
    field_wake_o |-> $past(q.drv_auto[`RMADC_BIT_WAKE_EN])
      && $past(soft_power_down_i) && $past(q.field_s2))
    else $error("wake without enable, power-down and field");

  external_signal_output_src_a: assert property (
    (sig_src == 4'h5) |=> external_signal_output_oe_o
      && external_signal_output_o == $past(tx_serial_i))
    else $error("signal output not following transmit stream");

  rate_pass_a: assert property (
    (rate_raw <= `RMADC_RATE_424) |-> receive_bit_rate_o == rate_raw)
    else $error("supported rate not passed through");

  frm_fallback_a: assert property (
    (frm_raw != `RMADC_FRM_ALT) |-> receive_frame_format_o == `RMADC_FRM_ISO)
    else $error("unlisted framing not mapped to base format");

  mode_update_a: assert property (
    mode_update_i |=> (rate_raw == $past(mode_update_rate_i))
      && (frm_raw == $past(mode_update_format_i)))
    else $error("hardware mode update lost");

  wr_drv_ctrl_a: assert property (
    (wr && idx == `RMADC_IDX_DRV_CTRL)
      |=> q.drv_ctrl == $past(wb_dat_i[7:0]))
    else $error("driver control write lost");

  drv_external_signal_input_a: assert property (
    (drv_src == 2'h2) |=> antenna_driver_pin_one_oe_o
      && antenna_driver_pin_one_o
         == ($past(q.external_signal_input_s2) ^ $past(q.drv_ctrl[`RMADC_BIT_INV_ONE])))
    else $error("driver not following external signal input");

  wake_single_a: assert property (
    field_wake_o |=> !field_wake_o)
    else $error("wake request longer than one cycle");

  frame_idle_a: assert property (
    (rx_frame_end_i && !q.rx_active) |=> !rx_frame_ok_o && !rx_crc_error_o
      && !rx_short_ignored_o && !rx_short_error_o)
    else $error("result reported for frame end while idle");

  short_ign_c: cover property (rx_short_ignored_o);
  crc_err_c: cover property (rx_crc_error_o);
  wake_c: cover property (field_wake_o);
  read_c: cover property (wb_ack_o && !wb_we_i);
endmodule : rmadc_config_regs

// ===== verification/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end
module tb;
  import rmadc_pkg::*;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]   wb_adr_i;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  logic [3:0]   wb_sel_i, g;
  logic         mode_update_i, rx_start_i, rx_bit_valid_i, rx_bit_i;
  logic         rx_frame_end_i, rx_active_o, rx_frame_ok_o, rx_crc_error_o;
  logic         rx_short_ignored_o, rx_short_error_o, checksum_en, e;
  rmadc_rate_t  mode_update_rate_i, receive_bit_rate_o;
  rmadc_frame_t mode_update_format_i, receive_frame_format_o;
  logic         soft_power_down_i, rf_field_detect_i, field_wake_o;
  logic         coder_envelope_i, tx_serial_i, rx_serial_i, external_signal_input;
  logic         pin1, pin1_oe, pin2, pin2_oe, external_signal_output, external_signal_output_oe;
  logic [7:0]   v;
  logic [15:0]  c;
  logic [3:0]   sc [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7};
  int           n_fail = 0;
  int           n_compared = 0;

  rmadc_config_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mode_update_i(mode_update_i), .mode_update_rate_i(mode_update_rate_i),
    .mode_update_format_i(mode_update_format_i), .rx_start_i(rx_start_i),
    .rx_bit_valid_i(rx_bit_valid_i), .rx_bit_i(rx_bit_i),
    .rx_frame_end_i(rx_frame_end_i), .rx_active_o(rx_active_o),
    .rx_frame_ok_o(rx_frame_ok_o), .rx_crc_error_o(rx_crc_error_o),
    .rx_short_ignored_o(rx_short_ignored_o),
    .rx_short_error_o(rx_short_error_o),
    .receive_bit_rate_o(receive_bit_rate_o),
    .receive_frame_format_o(receive_frame_format_o),
    .receive_checksum_enable_o(checksum_en),
    .soft_power_down_i(soft_power_down_i),
    .rf_field_detect_i(rf_field_detect_i), .field_wake_o(field_wake_o),
    .coder_envelope_i(coder_envelope_i), .tx_serial_i(tx_serial_i),
    .rx_serial_i(rx_serial_i), .external_signal_input_i(external_signal_input),
    .antenna_driver_pin_one_o(pin1), .antenna_driver_pin_one_oe_o(pin1_oe),
    .antenna_driver_pin_two_o(pin2), .antenna_driver_pin_two_oe_o(pin2_oe),
    .external_signal_output_o(external_signal_output),
    .external_signal_output_oe_o(external_signal_output_oe)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic xfer(input logic [5:0] idx, input logic we,
                      input logic [7:0] d, input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) n_fail++;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [7:0] x);
    xfer(idx, 1'b0, 8'h00, 4'hF);
    `CHK(q, {24'h0, x})
  endtask : rdc

  // bench's own checksum, appended msb first so residue ends at zero
  function automatic logic [15:0] crc_of(input logic [15:0] p,
                                         input logic [7:0] d);
    logic [15:0] r;
    r = p;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction : crc_of

  task automatic frm(input logic [31:0] b, input int n, input logic [3:0] x);
    @(posedge clk_i);
    rx_start_i <= 1'b1;
    @(posedge clk_i);
    rx_start_i <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit_valid_i <= 1'b1;
      rx_bit_i       <= b[i];
      @(posedge clk_i);
    end
    rx_bit_valid_i <= 1'b0;
    rx_frame_end_i <= 1'b1;
    @(posedge clk_i);
    rx_frame_end_i <= 1'b0;
    g = 4'h0;
    repeat (3) begin
      #1;
      g = g | {rx_frame_ok_o, rx_crc_error_o, rx_short_ignored_o,
               rx_short_error_o};
      @(posedge clk_i);
    end
    #1;
    `CHK(g, x)
  endtask : frm

  task automatic wake(input logic en, input logic [3:0] x);
    wr(6'h15, en ? 8'h20 : 8'h00);
    @(posedge clk_i);
    rf_field_detect_i <= 1'b1;
    g = 4'h0;
    repeat (8) begin
      @(posedge clk_i);
      #1;
      g = g + {3'h0, field_wake_o};
    end
    `CHK(g, x)
    @(posedge clk_i);
    rf_field_detect_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : wake

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    final_report();
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    rst_i = 1'b1;
    {mode_update_i, mode_update_rate_i, mode_update_format_i} = '0;
    {rx_start_i, rx_bit_valid_i, rx_bit_i, rx_frame_end_i} = '0;
    {soft_power_down_i, rf_field_detect_i, coder_envelope_i} = '0;
    {tx_serial_i, rx_serial_i, external_signal_input} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(6'h13, 8'h00);
    rdc(6'h14, 8'h80);
    rdc(6'h15, 8'h00);
    rdc(6'h16, 8'h10);
    `CHK(pin1_oe, 1'b1)
    wr(6'h00, 8'hFF);
    rdc(6'h00, 8'h00);
    xfer(6'h14, 1'b1, 8'h30, 4'hE);
    rdc(6'h14, 8'h80);
    wr(6'h15, 8'hFF);
    rdc(6'h15, 8'hEF);
    wr(6'h16, 8'hFF);
    rdc(6'h16, 8'h3F);
    $display("test register map done");
    for (int i = 0; i < 32; i++) begin
      v = {i[0], i[4:2], 2'b00, i[1:0]};
      wr(6'h13, v);
      rdc(6'h13, v);
      `CHK(receive_bit_rate_o, (i[4:2] <= 3'h2) ? i[4:2] : 3'h0)
      `CHK(receive_frame_format_o, i[1:0] == 2'h2 ? 2'h2 : 2'h0)
      `CHK(checksum_en, i[0])
    end
    wr(6'h13, 8'h88);
    @(posedge clk_i);
    mode_update_i        <= 1'b1;
    mode_update_rate_i   <= 3'h2;
    mode_update_format_i <= 2'h2;
    @(posedge clk_i);
    mode_update_i <= 1'b0;
    rdc(6'h13, 8'hAA);
    $display("test receive mode done");
    // power-down shares the inverted half so both cases see every source
    for (int i = 0; i < 16; i++) begin
      wr(6'h14, i[3] ? 8'h30 : 8'h00);
      wr(6'h16, {2'b00, i[1:0], 4'h0});
      @(posedge clk_i);
      coder_envelope_i  <= i[2];
      external_signal_input             <= ~i[2];
      soft_power_down_i <= i[3];
      repeat (6) @(posedge clk_i);
      #1;
      e = (i[1:0] == 2'h3) | (i[1:0] == 2'h1 & i[2])
          | (i[1:0] == 2'h2 & ~i[2]);
      `CHK(pin1_oe, i[1:0] != 2'h0)
      `CHK(pin2_oe, i[1:0] != 2'h0)
      if (i[1:0] != 2'h0) begin
        `CHK(pin1, e ^ i[3])
        `CHK(pin2, e ^ i[3])
      end
    end
    @(posedge clk_i);
    soft_power_down_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      wr(6'h16, {4'h1, sc[k]});
      for (int p = 0; p < 4; p++) begin
        @(posedge clk_i);
        coder_envelope_i <= p[0];
        tx_serial_i      <= p[1];
        rx_serial_i      <= p[0] ^ p[1];
        repeat (3) @(posedge clk_i);
        #1;
        case (sc[k])
          4'h1: e = 1'b0;
          4'h2: e = 1'b1;
          4'h4: e = p[0];
          4'h5: e = p[1];
          default: e = p[0] ^ p[1];
        endcase
        `CHK(external_signal_output_oe, sc[k] != 4'h0)
        if (sc[k] != 4'h0) `CHK(external_signal_output, e)
      end
    end
    $display("test pin sources done");
    wake(1'b1, 4'h0);
    @(posedge clk_i);
    soft_power_down_i <= 1'b1;
    wake(1'b1, 4'h1);
    wake(1'b0, 4'h0);
    soft_power_down_i <= 1'b0;
    wr(6'h15, 8'h20);
    @(posedge clk_i);
    rf_field_detect_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    soft_power_down_i <= 1'b1;
    g = 4'h0;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      g = g + {3'h0, field_wake_o};
    end
    `CHK(g, 4'h1)
    @(posedge clk_i);
    rf_field_detect_i <= 1'b0;
    soft_power_down_i <= 1'b0;
    $display("test wake done");
    wr(6'h13, 8'h08);
    frm(32'h5, 3, 4'b0010);
    `CHK(rx_active_o, 1'b1)
    wr(6'h13, 8'h00);
    frm(32'h5, 3, 4'b0001);
    `CHK(rx_active_o, 1'b0)
    frm(32'hA, 4, 4'b1000);
    for (int f = 0; f < 2; f++) begin
      wr(6'h13, f ? 8'hA2 : 8'h80);
      c = crc_of(f ? 16'h0000 : 16'h6363, 8'hA5);
      frm({8'h00, 8'hA5, c}, 24, 4'b1000);
      frm({8'h00, 8'hA5, c ^ 16'h0001}, 24, 4'b0100);
    end
    @(posedge clk_i);
    rx_frame_end_i <= 1'b1;
    @(posedge clk_i);
    rx_frame_end_i <= 1'b0;
    #1;
    `CHK({rx_frame_ok_o, rx_crc_error_o}, 2'h0)
    `CHK({rx_short_ignored_o, rx_short_error_o}, 2'h0)
    $display("test receive frames done");
    final_report();
  end
endmodule : tb
